// ===== rtl/tds_pkg.sv
// Constants and types for the tape drive status and attention block
package tds_pkg;
  // Register byte offsets
  localparam logic [7:0] TDS_A_STATUS   = 8'h00;
  localparam logic [7:0] TDS_A_CMD      = 8'h04;
  localparam logic [7:0] TDS_A_ATTN_SUM = 8'h08;
  localparam logic [7:0] TDS_A_CTRL     = 8'h0C;
  localparam logic [7:0] TDS_A_INT_STAT = 8'h10;
  localparam logic [7:0] TDS_A_INT_MASK = 8'h14;
  // Drive condition word field positions
  localparam int TDS_B_ATA = 15;
  localparam int TDS_B_ERR = 14;
  localparam int TDS_B_PIP = 13;
  localparam int TDS_B_MOL = 12;
  localparam int TDS_B_WRL = 11;
  localparam int TDS_B_EOT = 10;
  localparam int TDS_B_DPR = 8;
  localparam int TDS_B_DRY = 7;
  localparam int TDS_B_SSC = 6;
  // Command register fields
  localparam int TDS_B_GO   = 0;
  localparam int TDS_B_FUNC = 1;
  // Control register: controller clear
  localparam int TDS_B_CCLR = 0;
  // Interrupt status / mask bits
  localparam int TDS_I_ATTN = 0;
  localparam int TDS_I_EXC  = 1;
  localparam int TDS_I_REF  = 2;
  localparam int TDS_I_W    = 3;
  localparam logic [TDS_I_W-1:0] TDS_INT_RST = 3'h0;
  // AXI responses
  localparam logic [1:0] TDS_OKAY   = 2'h0;
  localparam logic [1:0] TDS_SLVERR = 2'h2;
  // Function codes
  typedef enum logic [2:0] {
    TDS_F_NOP    = 3'b000,
    TDS_F_DCLR   = 3'b001,
    TDS_F_REWIND = 3'b010,
    TDS_F_SPFWD  = 3'b011,
    TDS_F_SPREV  = 3'b100,
    TDS_F_WRITE  = 3'b101,
    TDS_F_READ   = 3'b110
  } tds_func_t;
  // Operation state
  typedef enum logic [1:0] {
    TDS_S_IDLE = 2'b00,
    TDS_S_XFER = 2'b01,
    TDS_S_POSN = 2'b10
  } tds_state_t;
  // Transport pins of the selected slave
  typedef struct packed {
    logic online;
    logic write_lock;
    logic eot_marker;
    logic reverse;
    logic rewind_done;
    logic power_fail;
  } tds_slave_t;
endpackage : tds_pkg

// ===== rtl/tds_status.sv
// Drive status word, error notification and attention logic
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) Class B aborts transfer; class A continues
// (R2) Any error in transfer raises exception
// (R3) Error while idle or rewinding raises attention
// (R4) Bit 15 shows an attention condition
// (R5) Clears, launched command, summary write clear attention
// (R6) Those two clears leave error indicators alone
// (R7) Status change, positioning done, END_OF_TAPE completion attend
// (R8) Bit 14 is OR of error register and unsafe flag
// (R9) Error summary cleared only by clears
// (R10) Only drive clear accepted while error summary
// (R11) Bit 13 set during space or rewind
// (R12) Bit 12 follows online, ignores clears
// (R13) Launch while offline: abort, unsafe, attention
// (R14) Every online change sets attention
// (R15) Bit 11 follows write lock, ignores clears
// (R16) Bit 10 set forward, cleared reverse marker
// (R17) END_OF_TAPE kept over clears, cleared by rewind
// (R18) Rewind done, power fail, online change flag
module tds_status #(
  parameter logic [2:0] UNIT_NUM = 3'h0
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire tds_pkg::tds_slave_t slave_pins,
  input  wire logic                sys_init,
  input  wire logic [15:0]         error_register,
  input  wire logic                class_a_err,
  input  wire logic                class_b_err,
  input  wire logic                op_done,
  output logic                     op_start,
  output tds_pkg::tds_func_t       op_code,
  output logic                     xfer_abort,
  output logic                     drive_clear,
  output logic                     unsafe_flag,
  output logic                     exception_line,
  output logic                     attention_line,
  output logic                     irq
);

  // Pin synchronisers; stage 1 feeds stage 2 only
  tds_pkg::tds_slave_t pin_s1;
  tds_pkg::tds_slave_t pin_s2;
  tds_pkg::tds_slave_t pin_s3;
  logic                init_s1;
  logic                init_s2;

  always_ff @(posedge aclk) begin
    pin_s1  <= slave_pins;
    pin_s2  <= pin_s1;
    pin_s3  <= pin_s2;
    init_s1 <= sys_init;
    init_s2 <= init_s1;
  end

  // State held by the block
  tds_pkg::tds_state_t  st;
  tds_pkg::tds_state_t  next_st;
  tds_pkg::tds_func_t   cur_op;
  logic                 slave_status_change;
  logic                 end_of_tape;
  localparam int TDS_IW = tds_pkg::TDS_I_W;
  logic [TDS_IW-1:0]    int_stat;
  logic [TDS_IW-1:0]    int_mask;

  // AXI write channel holding registers
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire do_wr   = aw_held & w_held & ~s_axi_bvalid;
  wire b_done  = s_axi_bvalid & s_axi_bready;
  wire lane0   = w_strb[0];
  wire lane1   = w_strb[1];

  // Write decode
  wire wr_cmd  = do_wr & (aw_addr == tds_pkg::TDS_A_CMD);
  wire wr_asum = do_wr & (aw_addr == tds_pkg::TDS_A_ATTN_SUM);
  wire wr_ctrl = do_wr & (aw_addr == tds_pkg::TDS_A_CTRL);
  wire wr_ist  = do_wr & (aw_addr == tds_pkg::TDS_A_INT_STAT);
  wire wr_imsk = do_wr & (aw_addr == tds_pkg::TDS_A_INT_MASK);
  wire wr_stat = do_wr & (aw_addr == tds_pkg::TDS_A_STATUS);
  wire wr_ok   = wr_cmd | wr_asum | wr_ctrl | wr_ist | wr_imsk | wr_stat;

  // Slave events seen on the synchronised pins
  wire medium_online      = pin_s2.online;
  wire write_locked      = pin_s2.write_lock;
  wire mol_chg  = pin_s2.online ^ pin_s3.online;
  wire rw_done  = pin_s2.rewind_done & ~pin_s3.rewind_done;
  wire pf_rise  = pin_s2.power_fail & ~pin_s3.power_fail;
  wire eot_edge = pin_s2.eot_marker & ~pin_s3.eot_marker;
  wire ssc_evt  = rw_done | pf_rise | mol_chg; // R18

  // Command decode; drive clear needs no launch bit test beyond go
  tds_pkg::tds_func_t wr_func;
  assign wr_func = tds_pkg::tds_func_t'(w_data[tds_pkg::TDS_B_FUNC +: 3]);
  wire launch    = wr_cmd & lane0 & w_data[tds_pkg::TDS_B_GO];
  wire is_dclr   = wr_func == tds_pkg::TDS_F_DCLR;
  wire is_xfer   = (wr_func == tds_pkg::TDS_F_WRITE) |
                   (wr_func == tds_pkg::TDS_F_READ);
  wire is_posn   = (wr_func == tds_pkg::TDS_F_REWIND) |
                   (wr_func == tds_pkg::TDS_F_SPFWD) |
                   (wr_func == tds_pkg::TDS_F_SPREV);

  // Error summary is the OR of the error bits
  wire esum      = (|error_register) | unsafe_flag; // R8

  // Clear sources: controller/system clear also implies drive clear
  wire gen_clr   = init_s2 | (wr_ctrl & lane0 & w_data[tds_pkg::TDS_B_CCLR]);
  wire dclr_cmd  = launch & is_dclr;
  wire dclr      = gen_clr | dclr_cmd; // R9

  // Command acceptance; error summary blocks all but drive clear
  wire refused   = launch & ~is_dclr & (esum | (st != tds_pkg::TDS_S_IDLE)); // R10
  wire go_ok     = launch & ~is_dclr & ~refused;
  wire offline   = go_ok & ~medium_online & (is_xfer | is_posn); // R13
  wire start     = go_ok & medium_online & (is_xfer | is_posn);

  // Operation end conditions
  wire in_xfer   = st == tds_pkg::TDS_S_XFER;
  wire in_posn   = st == tds_pkg::TDS_S_POSN;
  wire err_evt   = class_a_err | class_b_err;
  wire b_abort   = in_xfer & class_b_err; // R1
  wire op_end    = (in_xfer | in_posn) & op_done;

  // Attention set and clear terms; sets win over clears
  wire attn_set  = (ssc_evt & ~slave_status_change) |                 // R7
                   (in_posn & op_done) |              // R7
                   (op_end & end_of_tape) |                   // R7
                   mol_chg |                          // R14
                   offline |                          // R13
                   (err_evt & ~in_xfer);              // R3
  wire asum_hit  = wr_asum & lane0 & w_data[UNIT_NUM];
  wire attn_clr  = dclr | launch | asum_hit; // R5
  wire next_attn = attn_set | (attention_line & ~attn_clr);

  // Exception holds while the transfer stays under way
  wire next_exc  = (in_xfer & err_evt) | // R2
                   (exception_line & in_xfer & ~dclr & ~op_done & ~class_b_err);

  // Next operation state
  always_comb begin
    next_st = st;
    case (st)
      tds_pkg::TDS_S_IDLE: begin
        if (start & is_xfer) begin
          next_st = tds_pkg::TDS_S_XFER;
        end else if (start) begin
          next_st = tds_pkg::TDS_S_POSN;
        end
      end
      tds_pkg::TDS_S_XFER: begin
        if (class_b_err | op_done | dclr) begin // R1
          next_st = tds_pkg::TDS_S_IDLE;
        end
      end
      tds_pkg::TDS_S_POSN: begin
        if (op_done | dclr) begin // R11
          next_st = tds_pkg::TDS_S_IDLE;
        end
      end
      default: begin
        next_st = tds_pkg::TDS_S_IDLE;
      end
    endcase
  end

  // Operation state and the drive-facing strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= tds_pkg::TDS_S_IDLE;
      cur_op      <= tds_pkg::TDS_F_NOP;
      op_start    <= 1'b0;
      op_code     <= tds_pkg::TDS_F_NOP;
      xfer_abort  <= 1'b0;
      drive_clear <= 1'b0;
    end else begin
      st          <= next_st;
      op_start    <= start;
      xfer_abort  <= b_abort | offline; // R1
      drive_clear <= dclr;
      if (start) begin
        cur_op  <= wr_func;
        op_code <= wr_func;
      end
    end
  end

  // Attention, exception, unsafe and slave status change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      attention_line <= 1'b0;
      exception_line <= 1'b0;
      unsafe_flag    <= 1'b0;
      slave_status_change            <= 1'b0;
    end else begin
      attention_line <= next_attn; // R4
      exception_line <= next_exc;
      unsafe_flag    <= offline | (unsafe_flag & ~dclr); // R6
      slave_status_change            <= ssc_evt | (slave_status_change & ~dclr); // R18
    end
  end

  // END_OF_TAPE survives clears; only reset, a reverse marker or a rewind launch clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      end_of_tape <= 1'b0;
    end else if (eot_edge & ~pin_s2.reverse) begin
      end_of_tape <= 1'b1; // R16
    end else if ((eot_edge & pin_s2.reverse) |
                 (start & (wr_func == tds_pkg::TDS_F_REWIND))) begin
      end_of_tape <= 1'b0; // R17
    end
  end

  // Drive condition word
  logic [15:0] dcw;
  always_comb begin
    dcw                    = 16'h0000;
    dcw[tds_pkg::TDS_B_ATA] = attention_line; // R4
    dcw[tds_pkg::TDS_B_ERR] = esum; // R8
    dcw[tds_pkg::TDS_B_PIP] = in_posn; // R11
    dcw[tds_pkg::TDS_B_MOL] = medium_online; // R12
    dcw[tds_pkg::TDS_B_WRL] = write_locked; // R15
    dcw[tds_pkg::TDS_B_EOT] = end_of_tape; // R16
    dcw[tds_pkg::TDS_B_DPR] = 1'b1;
    dcw[tds_pkg::TDS_B_DRY] = st == tds_pkg::TDS_S_IDLE;
    dcw[tds_pkg::TDS_B_SSC] = slave_status_change;
  end

  // Interrupt events; a new event beats a write-one clear
  logic [TDS_IW-1:0] int_evt;
  assign int_evt[tds_pkg::TDS_I_ATTN] = next_attn & ~attention_line;
  assign int_evt[tds_pkg::TDS_I_EXC]  = next_exc & ~exception_line;
  assign int_evt[tds_pkg::TDS_I_REF]  = refused;
  wire [TDS_IW-1:0] ist_clr = (wr_ist & lane0) ? w_data[TDS_IW-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat <= tds_pkg::TDS_INT_RST;
      int_mask <= tds_pkg::TDS_INT_RST;
      irq      <= 1'b0;
    end else begin
      int_stat <= int_evt | (int_stat & ~ist_clr);
      if (wr_imsk & lane0) begin
        int_mask <= w_data[TDS_IW-1:0];
      end
      irq <= |(int_stat & int_mask);
    end
  end

  // AXI write: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tds_pkg::TDS_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? tds_pkg::TDS_OKAY : tds_pkg::TDS_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI read decode; unmapped reads answer zero with an error
  wire [7:0] ra = s_axi_araddr;
  wire rd_ok = (ra == tds_pkg::TDS_A_STATUS) | (ra == tds_pkg::TDS_A_CMD) |
               (ra == tds_pkg::TDS_A_ATTN_SUM) | (ra == tds_pkg::TDS_A_CTRL) |
               (ra == tds_pkg::TDS_A_INT_STAT) | (ra == tds_pkg::TDS_A_INT_MASK);
  wire [31:0] rd_mux =
    (ra == tds_pkg::TDS_A_STATUS)   ? {16'h0000, dcw} :
    (ra == tds_pkg::TDS_A_CMD)      ? {28'h0000000, cur_op, 1'b0} :
    (ra == tds_pkg::TDS_A_ATTN_SUM) ? {31'h00000000, attention_line} << UNIT_NUM :
    (ra == tds_pkg::TDS_A_INT_STAT) ? {29'h00000000, int_stat} :
    (ra == tds_pkg::TDS_A_INT_MASK) ? {29'h00000000, int_mask} :
    32'h0000_0000;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tds_pkg::TDS_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? tds_pkg::TDS_OKAY : tds_pkg::TDS_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks on the drive's own behaviour
  class_b_abort_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    in_xfer && class_b_err |=> xfer_abort && st == tds_pkg::TDS_S_IDLE)
    else $error("class B error did not abort transfer");

  class_a_cont_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    in_xfer && class_a_err && !class_b_err && !op_done && !dclr |=> in_xfer)
    else $error("class A error ended the transfer");

  exc_on_err_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    in_xfer && err_evt |=> exception_line)
    else $error("exception line missing after transfer error");

  idle_err_attn_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    !in_xfer && err_evt |=> attention_line && !exception_line)
    else $error("idle error did not raise attention");

  attn_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    attn_clr && !attn_set |=> !attention_line)
    else $error("attention not cleared");

  summary_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    unsafe_flag && !dclr |=> unsafe_flag)
    else $error("unsafe flag lost without a clear");

  refuse_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    launch && esum && !is_dclr |=> !op_start ##1 !op_start)
    else $error("command accepted while error summary set");

  pip_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    op_start && (op_code == tds_pkg::TDS_F_REWIND) |-> in_posn)
    else $error("positioning bit not set for rewind");

  offline_go_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    offline |=> unsafe_flag && attention_line && !op_start)
    else $error("offline launch not handled");

  mol_change_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    $changed(pin_s2.online) |=> attention_line)
    else $error("online change did not set attention");

  eot_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    eot_edge && !pin_s2.reverse |=> end_of_tape)
    else $error("end of tape not set on forward marker");

endmodule : tds_status
`default_nettype wire

// ===== tb/tds_far_end.sv
// Far-side model: drive error logic and transport completion
`timescale 1ns/1ps
`default_nettype none
module tds_far_end (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        op_start,
  input  wire logic        xfer_abort,
  input  wire logic        drive_clear,
  input  wire logic [7:0]  lat,
  input  wire logic        err_load,
  input  wire logic [15:0] err_val,
  output logic [15:0]      error_register,
  output logic             op_done
);
  logic [7:0] cnt;
  // Error bits held until a clear; completion lat cycles after start
  always_ff @(posedge aclk) begin
    op_done <= 1'b0;
    if (!aresetn) begin
      cnt            <= 8'h00;
      error_register <= 16'h0000;
    end else begin
      if (drive_clear) begin
        error_register <= 16'h0000;
      end else if (err_load) begin
        error_register <= err_val;
      end
      // An aborted operation never reports completion
      if (op_start) begin
        cnt <= lat;
      end else if (xfer_abort || drive_clear) begin
        cnt <= 8'h00;
      end else if (cnt == 8'h01) begin
        cnt     <= 8'h00;
        op_done <= 1'b1;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : tds_far_end
`default_nettype wire

// ===== tb/tds_status_tb.sv
// Self-checking bench for the drive status and attention block
`timescale 1ns/1ps
`default_nettype none
module tds_status_tb;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
  } tds_exp_t;
  localparam logic [31:0] S_ATTN = 32'h8000, S_SUMM = 32'h4000, S_POS = 32'h2000;
  localparam logic [31:0] S_ONL = 32'h1000, S_WLK = 32'h0800, S_END = 32'h0400;
  localparam logic [31:0] S_PRES = 32'h0100, S_CHG = 32'h0040, SM = 32'hFD00;
  logic                aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready, sys_init, cla, clb, op_done;
  logic                op_start, xfer_abort, drive_clear, unsafe_flag, irq, err_load;
  logic                exception_line, attention_line;
  logic [7:0]          awaddr, araddr, lat;
  logic [31:0]         wdata, rdata;
  logic [1:0]          bresp, rresp;
  logic [15:0]         err_reg, err_val;
  tds_pkg::tds_slave_t pins;
  tds_pkg::tds_func_t  op_code;
  tds_exp_t            rq[$];
  tds_exp_t            ex;
  logic [1:0]          bq[$];
  int                  bad_count, checks, aborts, starts, clears;
  integer              seed;

  tds_status u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slave_pins(pins),
    .sys_init(sys_init), .error_register(err_reg), .class_a_err(cla), .class_b_err(clb),
    .op_done(op_done), .op_start(op_start), .op_code(op_code), .xfer_abort(xfer_abort),
    .drive_clear(drive_clear), .unsafe_flag(unsafe_flag), .exception_line(exception_line),
    .attention_line(attention_line), .irq(irq));

  tds_far_end u_far (.aclk(aclk), .aresetn(aresetn), .op_start(op_start),
    .xfer_abort(xfer_abort), .drive_clear(drive_clear), .lat(lat), .err_load(err_load),
    .err_val(err_val), .error_register(err_reg), .op_done(op_done));

  // Clock at 20 MHz
  always #25 aclk = ~aclk;

  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Write: address and data offered together, each dropped when taken
  // Ready stays high after the first call; each call still assigns it high again
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    rq.push_back('{d: e, m: m, r: r});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask : rd

  task automatic st(input logic [31:0] e);
    rd(tds_pkg::TDS_A_STATUS, e, SM, tds_pkg::TDS_OKAY);
  endtask : st

  task automatic go(input tds_pkg::tds_func_t f);
    wr(tds_pkg::TDS_A_CMD, {28'h0, f, 1'b1}, tds_pkg::TDS_OKAY);
    cyc(2);
  endtask : go

  task automatic asum();
    wr(tds_pkg::TDS_A_ATTN_SUM, 32'h1, tds_pkg::TDS_OKAY);
  endtask : asum

  // One-cycle error pulse, class B when b is set
  task automatic epulse(input logic b);
    if (b) clb <= 1'b1;
    else cla <= 1'b1;
    @(posedge aclk);
    cla <= 1'b0;
    clb <= 1'b0;
    cyc(3);
  endtask : epulse

  // Marker crossing; pins pass a synchroniser, so allow settling time
  task automatic mark(input logic rev);
    pins.reverse    <= rev;
    pins.eot_marker <= 1'b1;
    cyc(6);
    pins.eot_marker <= 1'b0;
    cyc(6);
  endtask : mark

  task automatic conclude();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Response monitor: oldest note against each answer
  always @(posedge aclk) begin
    if (bvalid && bready) chk({30'h0, bq.pop_front()}, {30'h0, bresp}, "bresp");
    if (rvalid && rready) begin
      ex = rq.pop_front();
      chk(ex.d & ex.m, rdata & ex.m, "rdata");
      chk({30'h0, ex.r}, {30'h0, rresp}, "rresp");
    end
    if (xfer_abort) aborts++;
    if (op_start) starts++;
    if (drive_clear) clears++;
  end

  // Watchdog, far beyond the expected run length
  initial begin
    cyc(5000);
    bad_count++;
    conclude();
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sys_init} = 8'h00;
    {cla, clb, err_load, pins, awaddr, araddr, lat, wdata, err_val} = '0;
    seed = 32'hc061;
    cyc(16);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Online change, interrupt, summary clear, unmapped place
    wr(tds_pkg::TDS_A_INT_MASK, 32'h1, tds_pkg::TDS_OKAY);
    pins.online     <= 1'b1;
    pins.write_lock <= 1'b1;
    cyc(8);
    chk(32'h1, {31'h0, attention_line}, "attention_line");
    chk(32'h1, {31'h0, irq}, "irq");
    rd(8'h00, S_ATTN | S_ONL | S_WLK | S_PRES | S_CHG, SM | S_CHG, 2'h0);
    rd(tds_pkg::TDS_A_INT_STAT, 32'h1, 32'h7, tds_pkg::TDS_OKAY);
    wr(tds_pkg::TDS_A_INT_STAT, 32'h1, tds_pkg::TDS_OKAY);
    cyc(3);
    chk(32'h0, {31'h0, irq}, "irq");
    asum();
    st(S_ONL | S_WLK | S_PRES);
    wr(8'h18, 32'h1, tds_pkg::TDS_SLVERR);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, tds_pkg::TDS_SLVERR);
    $display("test online done");
    // End marker across clears, reverse crossing
    mark(1'b0);
    st(S_END | S_ONL | S_WLK | S_PRES);
    go(tds_pkg::TDS_F_DCLR);
    chk(32'h1, clears, "drive_clear");
    st(S_END | S_ONL | S_WLK | S_PRES);
    sys_init <= 1'b1;
    cyc(4);
    sys_init <= 1'b0;
    cyc(6);
    st(S_END | S_ONL | S_WLK | S_PRES);
    mark(1'b1);
    st(S_ONL | S_WLK | S_PRES);
    mark(1'b0);
    $display("test end_marker done");
    // Rewind: positioning flag, marker cleared, error while rewinding
    lat <= 8'h28;
    go(tds_pkg::TDS_F_REWIND);
    chk({29'h0, tds_pkg::TDS_F_REWIND}, {29'h0, op_code}, "op_code");
    st(S_POS | S_ONL | S_WLK | S_PRES);
    rd(tds_pkg::TDS_A_CMD, 32'h4, 32'hE, tds_pkg::TDS_OKAY);
    epulse(1'b0);
    chk(32'h1, {31'h0, attention_line}, "attention_line");
    // Clear it again so only the positioning completion can raise it
    asum();
    cyc(40);
    st(S_ATTN | S_ONL | S_WLK | S_PRES);
    $display("test rewind done");
    // Error while idle, refused command, then drive clear
    asum();
    err_val  <= 16'($random(seed)) | 16'h0001;
    err_load <= 1'b1;
    @(posedge aclk);
    err_load <= 1'b0;
    epulse(1'b0);
    chk(32'h1, {31'h0, attention_line}, "attention_line");
    chk(32'h0, {31'h0, exception_line}, "exception_line");
    st(S_ATTN | S_SUMM | S_ONL | S_WLK | S_PRES);
    asum();
    st(S_SUMM | S_ONL | S_WLK | S_PRES);
    go(tds_pkg::TDS_F_SPFWD);
    st(S_SUMM | S_ONL | S_WLK | S_PRES);
    rd(tds_pkg::TDS_A_INT_STAT, 32'h4, 32'h4, tds_pkg::TDS_OKAY);
    go(tds_pkg::TDS_F_DCLR);
    st(S_ONL | S_WLK | S_PRES);
    $display("test idle_error done");
    // Transfer: class A keeps it going, class B aborts it
    lat <= 8'hC8;
    go(tds_pkg::TDS_F_WRITE);
    chk(32'h2, starts, "op_start");
    epulse(1'b0);
    chk(32'h1, {31'h0, exception_line}, "exception_line");
    chk(32'h0, aborts, "xfer_abort");
    epulse(1'b1);
    chk(32'h1, aborts, "xfer_abort");
    chk(32'h0, {31'h0, exception_line}, "exception_line");
    go(tds_pkg::TDS_F_DCLR);
    $display("test transfer done");
    // Launch with the medium offline
    pins.online <= 1'b0;
    cyc(8);
    asum();
    go(tds_pkg::TDS_F_READ);
    chk(32'h1, {31'h0, unsafe_flag}, "unsafe_flag");
    chk(32'h2, aborts, "xfer_abort");
    st(S_ATTN | S_SUMM | S_WLK | S_PRES);
    go(tds_pkg::TDS_F_DCLR);
    chk(32'h0, {31'h0, unsafe_flag}, "unsafe_flag");
    // Power failure of the slave flags a status change and attention
    pins.power_fail <= 1'b1;
    cyc(6);
    rd(8'h00, S_ATTN | S_WLK | S_PRES | S_CHG, SM | S_CHG, 2'h0);
    $display("test offline done");
    conclude();
  end
endmodule : tds_status_tb
`default_nettype wire
